// ---- logic/gated_timer.v ----
// Added by the designer: register access over AXI4-Lite and the register offsets.
`timescale 1ns/10ps
// Overview of operation
// - software sets single-pulse enable, then go; counting starts on next gate edge
// - go bit clears itself on the trailing edge of the measured gate pulse
// - after completion no gate event counts until go is set again
// - clearing single-pulse enable clears go; go reads 1 armed, 0 done or idle
// - toggle plus single-pulse measures one full cycle of the gate source
// - read-only gate level status shows gate value regardless of gate enable
// - gate value falling edge sets gate event flag; enable gates its request
// - 16-bit counter wraps FFFF to 0000 and sets overflow flag
// - overflow request needs timer on, overflow, peripheral and global enables
// - in sleep counting continues only unsynchronized from the external source
// - overflow in sleep raises wake; service request still needs global enable
// - current count is copied to capture register on capture event
// - compare event when compare pair equals the count
// - compare trigger clears counter without setting overflow flag
// - software counter write beats a simultaneous trigger clear
// - prescale 11 div 8, 10 div 4, 01 div 2, 00 div 1
// - sync bit ignored for system clock sources, else 1 means unsynchronized
// - wide access bit set buffers the high byte, clear accesses it directly
// - timer-on enables counting; clearing it stops counter and clears toggle flop
// - gate enable ignored while off; when on it lets the gate control counting
// - gate polarity 1 counts while gate high, 0 while gate low
// - toggle flop flips on gate rising edge; held clear when toggle disabled
// - buffered mode: low read loads high buffer, low write loads buffered high
// - buffered mode: high write leaves prescaler, only low write clears it
`include "timer_defs.vh"

module gated_timer #(
  parameter AW = 8
) (
  // clock and reset
  input wire mclk,
  input wire rst_b,
  // axi4-lite write address
  input wire [AW-1:0] s_awaddr,
  input wire s_awvalid,
  output reg s_awready,
  // axi4-lite write data
  input wire [31:0] s_wdata,
  input wire [3:0] s_wstrb,
  input wire s_wvalid,
  output reg s_wready,
  // axi4-lite write response
  output reg [1:0] s_bresp,
  output reg s_bvalid,
  input wire s_bready,
  // axi4-lite read
  input wire [AW-1:0] s_araddr,
  input wire s_arvalid,
  output reg s_arready,
  output reg [31:0] s_rdata,
  output reg [1:0] s_rresp,
  output reg s_rvalid,
  input wire s_rready,
  // pins
  input wire ext_clk_in,
  input wire gate_in,
  input wire capture_in,
  // system
  input wire sleep_mode,
  // outputs
  output reg [15:0] count_value,
  output reg [15:0] capture_value,
  output reg compare_event,
  output reg overflow_irq,
  output reg gate_irq,
  output reg wake_req
);

  // ------------------------------------------------------------
  // bus slave
  // ------------------------------------------------------------
  reg aw_full_reg;
  reg w_full_reg;
  reg [AW-1:0] aw_addr_reg;
  reg [31:0] w_data_reg;
  reg [3:0] w_strb_reg;
  reg [31:0] rd_data;
  reg rd_hit;
  wire wr_fire;
  wire rd_fire;
  wire wr_hit;
  wire wr_lo;
  wire wr_hi;
  wire wr_ctl;
  wire wr_gate;
  wire wr_irq;
  wire wr_src;
  wire wr_cmp;
  wire rd_lo;

  assign wr_fire = aw_full_reg & w_full_reg & ~s_bvalid;
  assign rd_fire = s_arvalid & s_arready;
  assign wr_ctl = wr_fire & w_strb_reg[0] & (aw_addr_reg == `ADDR_CONTROL);
  assign wr_gate = wr_fire & w_strb_reg[0] & (aw_addr_reg == `ADDR_GATE);
  assign wr_lo = wr_fire & w_strb_reg[0] & (aw_addr_reg == `ADDR_CNT_LO);
  assign wr_hi = wr_fire & w_strb_reg[0] & (aw_addr_reg == `ADDR_CNT_HI);
  assign wr_irq = wr_fire & w_strb_reg[0] & (aw_addr_reg == `ADDR_IRQ);
  assign wr_src = wr_fire & w_strb_reg[0] & (aw_addr_reg == `ADDR_SOURCE);
  assign wr_cmp = wr_fire & (aw_addr_reg == `ADDR_COMPARE);
  assign rd_lo = rd_fire & (s_araddr == `ADDR_CNT_LO);
  assign wr_hit = (aw_addr_reg == `ADDR_CONTROL) | (aw_addr_reg == `ADDR_GATE) |
                  (aw_addr_reg == `ADDR_CNT_LO) | (aw_addr_reg == `ADDR_CNT_HI) |
                  (aw_addr_reg == `ADDR_IRQ) | (aw_addr_reg == `ADDR_SOURCE) |
                  (aw_addr_reg == `ADDR_COMPARE) | (aw_addr_reg == `ADDR_CAPTURE);

  // address and data taken in either order, response after both
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      aw_addr_reg <= {AW{1'b0}};
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      s_awready <= 1'b0;
      s_wready <= 1'b0;
      s_bvalid <= 1'b0;
      s_bresp <= `RESP_OKAY;
      s_arready <= 1'b0;
      s_rvalid <= 1'b0;
      s_rdata <= 32'h00000000;
      s_rresp <= `RESP_OKAY;
    end else begin
      if (s_awvalid & s_awready) begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= s_awaddr;
        s_awready <= 1'b0;
      end else if (s_bvalid & s_bready) begin
        aw_full_reg <= 1'b0;
        s_awready <= 1'b1;
      end else begin
        s_awready <= ~aw_full_reg;
      end
      if (s_wvalid & s_wready) begin
        w_full_reg <= 1'b1;
        w_data_reg <= s_wdata;
        w_strb_reg <= s_wstrb;
        s_wready <= 1'b0;
      end else if (s_bvalid & s_bready) begin
        w_full_reg <= 1'b0;
        s_wready <= 1'b1;
      end else begin
        s_wready <= ~w_full_reg;
      end
      if (wr_fire) begin
        s_bvalid <= 1'b1;
        s_bresp <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_bready) begin
        s_bvalid <= 1'b0;
      end
      if (rd_fire) begin
        s_arready <= 1'b0;
        s_rvalid <= 1'b1;
        s_rdata <= rd_data;
        s_rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_rvalid & s_rready) begin
        s_rvalid <= 1'b0;
        s_arready <= 1'b1;
      end else begin
        s_arready <= ~s_rvalid;
      end
    end
  end

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  reg [2:0] ext_sync_reg;
  reg [2:0] gate_sync_reg;
  reg [2:0] cap_sync_reg;

  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ext_sync_reg <= 3'h0;
      gate_sync_reg <= 3'h0;
      cap_sync_reg <= 3'h0;
    end else begin
      ext_sync_reg <= {ext_sync_reg[1:0], ext_clk_in};
      gate_sync_reg <= {gate_sync_reg[1:0], gate_in};
      cap_sync_reg <= {cap_sync_reg[1:0], capture_in};
    end
  end

  wire ext_rise = ext_sync_reg[1] & ~ext_sync_reg[2];
  wire gate_pin = gate_sync_reg[1];
  wire gate_rise = gate_sync_reg[1] & ~gate_sync_reg[2];
  wire cap_rise = cap_sync_reg[1] & ~cap_sync_reg[2];

  // ------------------------------------------------------------
  // control registers
  // ------------------------------------------------------------
  reg timer_on_reg;
  reg wide_access_buffer_enable_reg;
  reg sync_bypass_reg;
  reg [1:0] prescale_select_reg;
  reg gate_enable_reg;
  reg gate_polarity_reg;
  reg gate_toggle_enable_reg;
  reg single_pulse_enable_reg;
  reg pulse_acquire_go_status_reg;
  reg overflow_irq_enable_reg;
  reg gate_event_irq_enable_reg;
  reg peripheral_irq_enable_reg;
  reg global_irq_enable_reg;
  reg [1:0] clock_source_reg;
  reg trigger_enable_reg;
  reg [15:0] compare_reg;
  reg [15:0] count_reg;
  reg [7:0] high_buffer_reg;
  reg overflow_flag_reg;
  reg gate_event_flag_reg;
  reg toggle_reg;
  reg pulse_run_reg;
  reg pol_prev_reg;
  reg gate_value_prev_reg;
  reg compare_eq_prev_reg;
  reg [2:0] ps_cnt_reg;
  reg [1:0] div4_reg;
  reg [2:0] ps_limit;
  reg src_tick;

  // ------------------------------------------------------------
  // gate path
  // ------------------------------------------------------------
  wire gate_sel = gate_toggle_enable_reg ? toggle_reg : gate_pin;
  wire gate_pol = gate_polarity_reg ? gate_sel : ~gate_sel;
  wire pulse_start = pulse_acquire_go_status_reg & ~pulse_run_reg & gate_pol & ~pol_prev_reg;
  wire pulse_end = pulse_run_reg & ~gate_pol;
  // single-pulse passes only the one armed pulse
  wire gate_level_signal = single_pulse_enable_reg ? (pulse_run_reg & gate_pol) : gate_pol;

  // ------------------------------------------------------------
  // count tick
  // ------------------------------------------------------------
  // pin clock is always sampled; unsynchronized mode only changes sleep behaviour
  always @* begin
    case (clock_source_reg)
      `SRC_SYS: src_tick = 1'b1;
      `SRC_SYS4: src_tick = (div4_reg == `DIV4_LAST);
      `SRC_EXT: src_tick = ext_rise;
      default: src_tick = 1'b0;
    endcase
    case (prescale_select_reg)
      `PS_DIV1: ps_limit = `PS_LIM1;
      `PS_DIV2: ps_limit = `PS_LIM2;
      `PS_DIV4: ps_limit = `PS_LIM4;
      default: ps_limit = `PS_LIM8;
    endcase
  end

  wire ext_async = (clock_source_reg == `SRC_EXT) & sync_bypass_reg;
  wire sleep_ok = ~sleep_mode | ext_async;
  wire ps_tick = src_tick & (ps_cnt_reg == ps_limit);
  wire count_en = timer_on_reg & sleep_ok & (~gate_enable_reg | gate_level_signal);
  wire inc = ps_tick & count_en;
  wire ps_clear = wr_lo | (wr_hi & ~wide_access_buffer_enable_reg);
  wire compare_eq = (count_reg == compare_reg);
  wire trig_clear = trigger_enable_reg & compare_event;
  // a load or trigger clear in the wrap cycle replaces the increment, so no overflow
  wire count_load = wr_lo | (wr_hi & ~wide_access_buffer_enable_reg) | trig_clear;
  wire wrap = inc & (count_reg == `CNT_MAX) & ~count_load;

  // ------------------------------------------------------------
  // timer core
  // ------------------------------------------------------------
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      div4_reg <= 2'h0;
      ps_cnt_reg <= 3'h0;
      count_reg <= `CNT_ZERO;
      high_buffer_reg <= 8'h00;
      toggle_reg <= 1'b0;
      pulse_run_reg <= 1'b0;
      pol_prev_reg <= 1'b0;
      gate_value_prev_reg <= 1'b0;
      compare_eq_prev_reg <= 1'b0;
    end else begin
      div4_reg <= div4_reg + 2'h1;
      if (ps_clear) begin
        ps_cnt_reg <= 3'h0;
      end else if (src_tick & timer_on_reg & sleep_ok) begin
        ps_cnt_reg <= ps_tick ? 3'h0 : ps_cnt_reg + 3'h1;
      end
      if (wr_lo) begin
        count_reg <= {(wide_access_buffer_enable_reg ? high_buffer_reg : count_reg[15:8]),
                      w_data_reg[7:0]};
      end else if (wr_hi & ~wide_access_buffer_enable_reg) begin
        count_reg <= {w_data_reg[7:0], count_reg[7:0]};
      end else if (trig_clear) begin
        count_reg <= `CNT_ZERO;
      end else if (inc) begin
        count_reg <= count_reg + 16'h0001;
      end
      if (rd_lo & wide_access_buffer_enable_reg) begin
        high_buffer_reg <= count_reg[15:8];
      end else if (wr_hi & wide_access_buffer_enable_reg) begin
        high_buffer_reg <= w_data_reg[7:0];
      end
      if (~timer_on_reg | ~gate_toggle_enable_reg) begin
        toggle_reg <= 1'b0;
      end else if (gate_rise) begin
        toggle_reg <= ~toggle_reg;
      end
      if (~pulse_acquire_go_status_reg | pulse_end) begin
        pulse_run_reg <= 1'b0;
      end else if (pulse_start) begin
        pulse_run_reg <= 1'b1;
      end
      pol_prev_reg <= gate_pol;
      gate_value_prev_reg <= gate_level_signal;
      compare_eq_prev_reg <= compare_eq;
    end
  end

  // ------------------------------------------------------------
  // software registers and flags
  // ------------------------------------------------------------
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      timer_on_reg <= 1'b0;
      wide_access_buffer_enable_reg <= 1'b0;
      sync_bypass_reg <= 1'b0;
      prescale_select_reg <= `PS_DIV1;
      gate_enable_reg <= 1'b0;
      gate_polarity_reg <= 1'b0;
      gate_toggle_enable_reg <= 1'b0;
      single_pulse_enable_reg <= 1'b0;
      pulse_acquire_go_status_reg <= 1'b0;
      overflow_irq_enable_reg <= 1'b0;
      gate_event_irq_enable_reg <= 1'b0;
      peripheral_irq_enable_reg <= 1'b0;
      global_irq_enable_reg <= 1'b0;
      clock_source_reg <= `SRC_SYS;
      trigger_enable_reg <= 1'b0;
      compare_reg <= `CNT_ZERO;
      overflow_flag_reg <= 1'b0;
      gate_event_flag_reg <= 1'b0;
    end else begin
      if (wr_ctl) begin
        timer_on_reg <= w_data_reg[`CTL_ON];
        wide_access_buffer_enable_reg <= w_data_reg[`CTL_WIDE];
        sync_bypass_reg <= w_data_reg[`CTL_SYNC];
        prescale_select_reg <= w_data_reg[`CTL_PS_HI:`CTL_PS_LO];
      end
      if (wr_gate) begin
        gate_enable_reg <= w_data_reg[`GT_EN];
        gate_polarity_reg <= w_data_reg[`GT_POL];
        gate_toggle_enable_reg <= w_data_reg[`GT_TGL];
        single_pulse_enable_reg <= w_data_reg[`GT_SP];
        // go only arms while single-pulse stays enabled
        pulse_acquire_go_status_reg <= w_data_reg[`GT_SP] & w_data_reg[`GT_GO];
      end else if (~single_pulse_enable_reg | pulse_end) begin
        pulse_acquire_go_status_reg <= 1'b0;
      end
      if (wr_irq) begin
        overflow_irq_enable_reg <= w_data_reg[`IRQ_OVF_EN];
        gate_event_irq_enable_reg <= w_data_reg[`IRQ_GATE_EN];
        peripheral_irq_enable_reg <= w_data_reg[`IRQ_PERIPH_EN];
        global_irq_enable_reg <= w_data_reg[`IRQ_GLOBAL_EN];
      end
      if (wr_src) begin
        clock_source_reg <= w_data_reg[`SRC_HI:`SRC_LO];
        trigger_enable_reg <= w_data_reg[`SRC_TRIG_EN];
      end
      if (wr_cmp & w_strb_reg[0]) begin
        compare_reg[7:0] <= w_data_reg[7:0];
      end
      if (wr_cmp & w_strb_reg[1]) begin
        compare_reg[15:8] <= w_data_reg[15:8];
      end
      // write one clears; a same-cycle event wins
      if (wrap) begin
        overflow_flag_reg <= 1'b1;
      end else if (wr_irq & w_data_reg[`IRQ_OVF_FLAG]) begin
        overflow_flag_reg <= 1'b0;
      end
      if (gate_value_prev_reg & ~gate_level_signal) begin
        gate_event_flag_reg <= 1'b1;
      end else if (wr_irq & w_data_reg[`IRQ_GATE_FLAG]) begin
        gate_event_flag_reg <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------
  always @* begin
    rd_data = 32'h00000000;
    rd_hit = 1'b1;
    case (s_araddr)
      `ADDR_CONTROL: begin
        rd_data[`CTL_ON] = timer_on_reg;
        rd_data[`CTL_WIDE] = wide_access_buffer_enable_reg;
        rd_data[`CTL_SYNC] = sync_bypass_reg;
        rd_data[`CTL_PS_HI:`CTL_PS_LO] = prescale_select_reg;
      end
      `ADDR_GATE: begin
        rd_data[`GT_EN] = gate_enable_reg;
        rd_data[`GT_POL] = gate_polarity_reg;
        rd_data[`GT_TGL] = gate_toggle_enable_reg;
        rd_data[`GT_SP] = single_pulse_enable_reg;
        rd_data[`GT_GO] = pulse_acquire_go_status_reg;
        rd_data[`GT_VAL] = gate_level_signal;
      end
      `ADDR_CNT_LO: rd_data[7:0] = count_reg[7:0];
      `ADDR_CNT_HI: rd_data[7:0] = wide_access_buffer_enable_reg ? high_buffer_reg : count_reg[15:8];
      `ADDR_IRQ: begin
        rd_data[`IRQ_OVF_FLAG] = overflow_flag_reg;
        rd_data[`IRQ_GATE_FLAG] = gate_event_flag_reg;
        rd_data[`IRQ_OVF_EN] = overflow_irq_enable_reg;
        rd_data[`IRQ_GATE_EN] = gate_event_irq_enable_reg;
        rd_data[`IRQ_PERIPH_EN] = peripheral_irq_enable_reg;
        rd_data[`IRQ_GLOBAL_EN] = global_irq_enable_reg;
      end
      `ADDR_SOURCE: begin
        rd_data[`SRC_HI:`SRC_LO] = clock_source_reg;
        rd_data[`SRC_TRIG_EN] = trigger_enable_reg;
      end
      `ADDR_COMPARE: rd_data[15:0] = compare_reg;
      `ADDR_CAPTURE: rd_data[15:0] = capture_value;
      default: rd_hit = 1'b0;
    endcase
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      count_value <= `CNT_ZERO;
      capture_value <= `CNT_ZERO;
      compare_event <= 1'b0;
      overflow_irq <= 1'b0;
      gate_irq <= 1'b0;
      wake_req <= 1'b0;
    end else begin
      count_value <= count_reg;
      if (cap_rise) begin
        capture_value <= count_reg;
      end
      compare_event <= compare_eq & ~compare_eq_prev_reg;
      overflow_irq <= overflow_flag_reg & timer_on_reg & overflow_irq_enable_reg &
                      peripheral_irq_enable_reg & global_irq_enable_reg;
      gate_irq <= gate_event_flag_reg & gate_event_irq_enable_reg &
                  peripheral_irq_enable_reg & global_irq_enable_reg;
      // wake needs no global enable; vectoring still does
      wake_req <= sleep_mode & overflow_flag_reg & timer_on_reg &
                  overflow_irq_enable_reg & peripheral_irq_enable_reg;
    end
  end

endmodule // gated_timer

// ---- logic/timer_defs.vh ----
`ifndef TIMER_DEFS_VH
`define TIMER_DEFS_VH

// ------------------------------------------------------------
// register byte addresses
// ------------------------------------------------------------
`define ADDR_CONTROL 8'h00
`define ADDR_GATE 8'h04
`define ADDR_CNT_LO 8'h08
`define ADDR_CNT_HI 8'h0C
`define ADDR_IRQ 8'h10
`define ADDR_SOURCE 8'h14
`define ADDR_COMPARE 8'h18
`define ADDR_CAPTURE 8'h1C

// ------------------------------------------------------------
// timer_control fields
// ------------------------------------------------------------
`define CTL_ON 0
`define CTL_WIDE 1
`define CTL_SYNC 2
`define CTL_PS_LO 4
`define CTL_PS_HI 5
`define CTL_RESET 8'h00

// ------------------------------------------------------------
// timer_gate_control fields
// ------------------------------------------------------------
`define GT_EN 7
`define GT_POL 6
`define GT_TGL 5
`define GT_SP 4
`define GT_GO 3
`define GT_VAL 2
`define GT_RESET 4'h0

// ------------------------------------------------------------
// irq_control fields
// ------------------------------------------------------------
`define IRQ_OVF_FLAG 0
`define IRQ_GATE_FLAG 1
`define IRQ_OVF_EN 2
`define IRQ_GATE_EN 3
`define IRQ_PERIPH_EN 4
`define IRQ_GLOBAL_EN 5

// ------------------------------------------------------------
// timer_source fields and codes
// ------------------------------------------------------------
`define SRC_LO 0
`define SRC_HI 1
`define SRC_TRIG_EN 4
`define SRC_SYS 2'h0
`define SRC_SYS4 2'h1
`define SRC_EXT 2'h2

// ------------------------------------------------------------
// prescale codes and limits
// ------------------------------------------------------------
`define PS_DIV1 2'h0
`define PS_DIV2 2'h1
`define PS_DIV4 2'h2
`define PS_DIV8 2'h3
`define PS_LIM1 3'h0
`define PS_LIM2 3'h1
`define PS_LIM4 3'h3
`define PS_LIM8 3'h7

// ------------------------------------------------------------
// misc
// ------------------------------------------------------------
`define CNT_MAX 16'hFFFF
`define CNT_ZERO 16'h0000
`define DIV4_LAST 2'h3
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ---- test/gated_timer_props.sv ----
`timescale 1ns/10ps
// ------------------------------------------------------------
// port checker
// ------------------------------------------------------------
module gated_timer_props (
  // clock and reset
  input wire mclk,
  input wire rst_b,
  // bus handshakes
  input wire s_awready,
  input wire s_wready,
  input wire s_bvalid,
  input wire s_bready,
  input wire s_arready,
  input wire s_rvalid,
  input wire s_rready,
  input wire [31:0] s_rdata,
  // timer side
  input wire sleep_mode,
  input wire [15:0] count_value,
  input wire compare_event,
  input wire overflow_irq,
  input wire wake_req
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  a_b_hold: assert property (s_bvalid && !s_bready |=> s_bvalid)
    else $error("write response dropped early");
  a_r_hold: assert property (s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
    else $error("read data dropped or changed early");
  a_w_busy: assert property (s_bvalid |-> !s_awready && !s_wready)
    else $error("write taken while response pending");
  a_ar_busy: assert property (s_rvalid |-> !s_arready)
    else $error("read taken while data pending");
  a_cmp_pulse: assert property (compare_event |=> !compare_event)
    else $error("compare event longer than one cycle");
  // bus writes may load any value, so they are excluded
  a_count_step: assert property ($changed(count_value) && !s_bvalid |->
    count_value == $past(count_value) + 16'h0001 || count_value == 16'h0000)
    else $error("count moved by other than one");
  a_wake_sleep: assert property (wake_req |-> $past(sleep_mode))
    else $error("wake raised while awake");
  a_ovf_wake: assert property (overflow_irq && $past(sleep_mode) |-> wake_req)
    else $error("overflow in sleep gave no wake");
endmodule // gated_timer_props

// ---- test/testbench.sv ----
`timescale 1ns/10ps
`include "timer_defs.vh"
module testbench;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] m; logic [31:0] e; logic [1:0] r;} row_t;
  logic mclk, rst_b, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready;
  logic gate_in, capture_in, sleep_mode;
  logic ext_clk_in = 1'b0;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, compare_event, overflow_irq, gate_irq, wake_req;
  logic [7:0] s_awaddr, s_araddr;
  logic [31:0] s_wdata, s_rdata, rdv;
  logic [3:0] s_wstrb;
  logic [1:0] s_bresp, s_rresp, rsp;
  logic [15:0] count_value, capture_value, v, mx;
  int n_fail, checked, cyc, n;
  row_t rows [6] = '{'{`ADDR_CONTROL, 32'h36, 32'hFF, 32'h36, 2'h0},
    '{`ADDR_GATE, 32'hE0, 32'hFB, 32'hE0, 2'h0}, '{`ADDR_SOURCE, 32'h12, 32'hFF, 32'h12, 2'h0},
    '{`ADDR_COMPARE, 32'hABCD, 32'hFFFF, 32'hABCD, 2'h0},
    '{`ADDR_CAPTURE, 32'h55, 32'hFFFF, 32'h0, 2'h0}, '{8'h40, 32'h1, 32'hFFFFFFFF, 32'h0, 2'h2}};

  gated_timer i_gated_timer (.*);

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // free-running external clock, toggled every cycle, rising edges every two cycles
  always @(posedge mclk) begin
    ext_clk_in <= ~ext_clk_in;
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_fail++;
      stop_test();
    end
  end

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic reset_dut();
    rst_b <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (2) @(posedge mclk);
  endtask

  // ready is raised late on purpose so the slave must hold its answer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_awready) s_awvalid <= 1'b0;
      if (s_wready) s_wvalid <= 1'b0;
    end while (!s_bvalid);
    s_bready <= 1'b1;
    @(posedge mclk);
    rsp = s_bresp;
    s_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_arready) s_arvalid <= 1'b0;
    end while (!s_rvalid);
    s_rready <= 1'b1;
    @(posedge mclk);
    rdv = s_rdata;
    rsp = s_rresp;
    s_rready <= 1'b0;
  endtask

  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, gate_in, capture_in, sleep_mode} = '0;
    {s_awaddr, s_araddr, s_wdata} = '0;
    s_wstrb = 4'hF;
    rst_b = 1'b1;
    reset_dut();
    for (int a = 0; a < 32; a += 4) begin
      rd(a[7:0]);
      chk(rdv & (a == 4 ? 32'hFB : 32'hFFFFFFFF), 32'h0);
    end
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      chk({30'h0, rsp}, {30'h0, rows[i].r});
      rd(rows[i].a);
      chk(rdv & rows[i].m, rows[i].e);
      chk({30'h0, rsp}, {30'h0, rows[i].r});
    end
    $display("register table done");
    for (int c = 0; c < 4; c++) begin
      reset_dut();
      wr(`ADDR_CONTROL, 32'h01 | (c << 4));
      repeat (8) @(posedge mclk);
      v = count_value;
      repeat (64) @(posedge mclk);
      chk(count_value - v, 64 >> c);
    end
    $display("prescale done");
    reset_dut();
    wr(`ADDR_IRQ, 32'h1C);
    wr(`ADDR_CNT_HI, 32'hFF);
    wr(`ADDR_CNT_LO, 32'hF0);
    wr(`ADDR_CONTROL, 32'h01);
    repeat (40) @(posedge mclk);
    chk(overflow_irq, 1'b0);
    rd(`ADDR_IRQ);
    chk(rdv, 32'h1D);
    wr(`ADDR_IRQ, 32'h3D);
    rd(`ADDR_IRQ);
    chk(rdv, 32'h3C);
    wr(`ADDR_CNT_HI, 32'hFF);
    wr(`ADDR_CNT_LO, 32'hF0);
    repeat (40) @(posedge mclk);
    chk(overflow_irq, 1'b1);
    sleep_mode <= 1'b1;
    repeat (4) @(posedge mclk);
    v = count_value;
    repeat (20) @(posedge mclk);
    chk(count_value, v);
    chk(wake_req, 1'b1);
    wr(`ADDR_SOURCE, 32'h02);
    wr(`ADDR_CONTROL, 32'h05);
    v = count_value;
    repeat (40) @(posedge mclk);
    chk(count_value != v, 1'b1);
    sleep_mode <= 1'b0;
    $display("overflow and sleep done");
    reset_dut();
    wr(`ADDR_COMPARE, 32'h20);
    wr(`ADDR_SOURCE, 32'h10);
    wr(`ADDR_CONTROL, 32'h01);
    n = 0;
    mx = 16'h0000;
    repeat (120) begin
      @(posedge mclk);
      n += compare_event;
      if (count_value > mx) mx = count_value;
    end
    chk(n > 1 && mx < 16'h0024, 1'b1);
    rd(`ADDR_IRQ);
    chk(rdv & 32'h1, 32'h0);
    $display("compare trigger done");
    reset_dut();
    wr(`ADDR_GATE, 32'hC0);
    wr(`ADDR_CONTROL, 32'h01);
    v = count_value;
    repeat (20) @(posedge mclk);
    chk(count_value, v);
    gate_in <= 1'b1;
    repeat (20) @(posedge mclk);
    rd(`ADDR_GATE);
    chk(rdv & 32'h4, 32'h4);
    chk(count_value != v, 1'b1);
    gate_in <= 1'b0;
    repeat (5) @(posedge mclk);
    rd(`ADDR_IRQ);
    chk(rdv & 32'h2, 32'h2);
    chk(gate_irq, 1'b0);
    wr(`ADDR_IRQ, 32'h38);
    repeat (2) @(posedge mclk);
    chk(gate_irq, 1'b1);
    wr(`ADDR_GATE, 32'hD0);
    wr(`ADDR_GATE, 32'hD8);
    rd(`ADDR_GATE);
    chk(rdv & 32'h8, 32'h8);
    for (int p = 0; p < 2; p++) begin
      v = count_value;
      gate_in <= 1'b1;
      repeat (30) @(posedge mclk);
      gate_in <= 1'b0;
      repeat (6) @(posedge mclk);
      rd(`ADDR_GATE);
      chk(rdv & 32'h8, 32'h0);
      chk(count_value != v, p == 0);
    end
    wr(`ADDR_GATE, 32'hD8);
    // go asked for with single-pulse off must read back clear
    wr(`ADDR_GATE, 32'hC8);
    rd(`ADDR_GATE);
    chk(rdv & 32'h8, 32'h0);
    $display("gate done");
    // gate held closed, so the count stands still for the capture
    wr(`ADDR_CNT_HI, 32'h12);
    wr(`ADDR_CNT_LO, 32'h34);
    capture_in <= 1'b1;
    repeat (5) @(posedge mclk);
    capture_in <= 1'b0;
    chk(capture_value, 16'h1234);
    rd(`ADDR_CAPTURE);
    chk(rdv, 32'h1234);
    wr(`ADDR_CONTROL, 32'h02);
    wr(`ADDR_CNT_HI, 32'h56);
    chk(count_value, 16'h1234);
    rd(`ADDR_CNT_HI);
    chk(rdv, 32'h56);
    wr(`ADDR_CNT_LO, 32'h78);
    chk(count_value, 16'h5678);
    wr(`ADDR_CNT_HI, 32'h9A);
    rd(`ADDR_CNT_LO);
    chk(rdv, 32'h78);
    rd(`ADDR_CNT_HI);
    chk(rdv, 32'h56);
    $display("capture and buffer done");
    stop_test();
  end
endmodule // testbench

bind gated_timer gated_timer_props i_props (.*);
